// >>> hw/csm_core_regs.sv
// Core mode, page pointer, stack pointer and address extension logic
`timescale 1ns/100ps
`default_nettype none
`include "csm_defines.svh"

module csm_core_regs #(
	parameter logic [63:0] INT_SEG_MAP = 64'h0000_0000_0000_0001
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	// Register file port from the core
	input  wire logic [7:0]           reg_addr,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [7:0]           reg_wdata,
	output logic      [7:0]           reg_rdata,
	// Set-page instruction
	input  wire logic                 spp_load,
	input  wire logic [5:0]           spp_value,
	// Explicit push and pop
	input  wire logic                 stk_req,
	input  wire logic                 stk_push,
	input  wire logic                 stk_user,
	input  wire logic                 stk_word,
	input  wire logic [15:0]          stk_wdata,
	// Automatic pushes
	input  wire logic                 irq_entry,
	input  wire logic                 call_plain,
	input  wire logic                 call_seg,
	input  wire logic [15:0]          prog_counter,
	input  wire logic [7:0]           flag_reg,
	output logic                      stk_busy,
	output logic [15:0]               stk_addr,
	output logic [15:0]               stk_data,
	output logic                      stk_we,
	output logic                      stk_rd,
	output logic                      stk_word_out,
	output logic                      stk_internal,
	// Clock enables
	output logic                      internal_clock,
	output logic                      processor_clock,
	// External bus control
	input  wire logic                 bus_request_pin,
	output logic                      bus_request_grant,
	input  wire logic [15:0]          ext_addr_lines,
	output logic [15:0]               ext_lines_float,
	output logic                      strobes_float,
	// Address extension
	input  wire logic                 mmu_req,
	input  wire csm_pkg::csm_access_t mmu_kind,
	input  wire logic                 irq_use_isr,
	input  wire logic                 dma_use_dma_segment_reg,
	input  wire logic [15:0]          mmu_vaddr,
	output logic [21:0]               mmu_paddr,
	output logic                      mmu_external,
	output logic                      mmu_valid
);

	csm_pkg::csm_state_t s;
	csm_pkg::csm_state_t n;

	// ==========================================================================
	// Helpers
	// Internal stacks wrap within the low byte; high byte left untouched
	function automatic logic [15:0] sp_step(
		input logic [15:0] sp,
		input logic        internal,
		input logic        down,
		input logic        word
	);
		logic [15:0] d;
		logic [15:0] r;
		d = word ? 16'h0002 : 16'h0001;
		r = down ? sp - d : sp + d;
		sp_step = internal ? {sp[15:8], r[7:0]} : r;
	endfunction

	function automatic logic [15:0] sp_addr(input logic [15:0] sp, input logic internal);
		sp_addr = internal ? {8'h00, sp[7:0]} : sp;
	endfunction

	// ==========================================================================
	// Next state
	always_comb begin
		logic [7:0]  rv;
		logic [15:0] sp;
		logic        inl;
		logic [5:0]  seg;
		rv = 8'h00;
		sp = 16'h0000;
		inl = 1'b0;
		seg = 6'h00;
		n = s;
		n.stk_we = 1'b0;
		n.stk_rd = 1'b0;
		n.int_clk_en = 1'b0;
		n.cpu_clk_en = 1'b0;
		n.paddr_vld = 1'b0;

		// Oscillator halving then prescaler, both as enables
		n.osc_tog = ~s.osc_tog;
		if (!s.mode[`CSM_MODE_OSCILLATOR_HALVING] || s.osc_tog) begin
			n.int_clk_en = 1'b1;
			if (s.pre_cnt >= s.mode[`CSM_MODE_PRS_HI:`CSM_MODE_PRS_LO]) begin
				n.pre_cnt = 3'h0;
				n.cpu_clk_en = 1'b1;
			end else begin
				n.pre_cnt = s.pre_cnt + 3'h1;
			end
		end

		// Bus request gating and float control
		n.bus_grant = bus_request_pin & s.mode[`CSM_MODE_BUS_REQUEST_ENABLE];
		n.strobes_float = s.mode[`CSM_MODE_BUS_FLOAT_ENABLE];
		// Only lines configured as address or data float; I/O pins excluded
		n.pins_float = ext_addr_lines & {16{s.mode[`CSM_MODE_BUS_FLOAT_ENABLE]}};

		// Set-page instruction
		if (spp_load) begin
			n.page = spp_value;
		end

		// Register writes
		if (reg_wr) begin
			if (reg_addr == `CSM_R_PAGE) begin
				n.page = reg_wdata[7:2];
			end else if (reg_addr == `CSM_R_MODE) begin
				n.mode = reg_wdata;
			end else if (reg_addr == `CSM_R_USP_HI) begin
				n.user_stack_internal_sel[15:8] = reg_wdata;
			end else if (reg_addr == `CSM_R_USP_LO) begin
				n.user_stack_internal_sel[7:0] = reg_wdata;
			end else if (reg_addr == `CSM_R_SSP_HI) begin
				n.system_stack_internal_sel[15:8] = reg_wdata;
			end else if (reg_addr == `CSM_R_SSP_LO) begin
				n.system_stack_internal_sel[7:0] = reg_wdata;
			end else if (s.dpr_reloc && reg_addr[7:2] == `CSM_R_DPR_RELOC >> 2) begin
				n.data_page_regs[reg_addr[1:0]] = reg_wdata;
			end else if (s.page == `CSM_MMU_PAGE) begin
				if (!s.dpr_reloc && reg_addr[7:2] == `CSM_R_DPR0 >> 2) begin
					n.data_page_regs[reg_addr[1:0]] = reg_wdata;
				end else if (reg_addr == `CSM_R_CSR) begin
					n.code_segment_reg = reg_wdata[5:0];
				end else if (reg_addr == `CSM_R_EXTENDED_MODE_REG_TWO) begin
					n.seg_push = reg_wdata[`CSM_EXTENDED_MODE_REG_TWO_SEGPUSH];
					n.dpr_reloc = reg_wdata[`CSM_EXTENDED_MODE_REG_TWO_RELOC];
				end else if (reg_addr == `CSM_R_ISR) begin
					n.interrupt_segment_reg = reg_wdata[5:0];
				end else if (reg_addr == `CSM_R_DMA_SEGMENT_REG) begin
					n.dma_segment_reg = reg_wdata[5:0];
				end
			end
		end

		// Register reads, answered one cycle later
		if (reg_addr == `CSM_R_PAGE) begin
			rv = {s.page, 2'b00};
		end else if (reg_addr == `CSM_R_MODE) begin
			rv = s.mode;
		end else if (reg_addr == `CSM_R_USP_HI) begin
			rv = s.user_stack_internal_sel[15:8];
		end else if (reg_addr == `CSM_R_USP_LO) begin
			rv = s.user_stack_internal_sel[7:0];
		end else if (reg_addr == `CSM_R_SSP_HI) begin
			rv = s.system_stack_internal_sel[15:8];
		end else if (reg_addr == `CSM_R_SSP_LO) begin
			rv = s.system_stack_internal_sel[7:0];
		end else if (s.dpr_reloc && reg_addr[7:2] == `CSM_R_DPR_RELOC >> 2) begin
			rv = s.data_page_regs[reg_addr[1:0]];
		end else if (s.page == `CSM_MMU_PAGE) begin
			if (!s.dpr_reloc && reg_addr[7:2] == `CSM_R_DPR0 >> 2) begin
				rv = s.data_page_regs[reg_addr[1:0]];
			end else if (reg_addr == `CSM_R_CSR) begin
				rv = {2'b00, s.code_segment_reg};
			end else if (reg_addr == `CSM_R_EXTENDED_MODE_REG_TWO) begin
				rv = {s.seg_push, 1'b0, s.dpr_reloc, 5'h00};
			end else if (reg_addr == `CSM_R_ISR) begin
				rv = {2'b00, s.interrupt_segment_reg};
			end else if (reg_addr == `CSM_R_DMA_SEGMENT_REG) begin
				rv = {2'b00, s.dma_segment_reg};
			end
		end
		if (reg_rd) begin
			n.rd_data = rv;
		end

		// Stack sequencer; automatic pushes go to the system stack
		inl = s.mode[`CSM_MODE_SSP];
		case (s.fsm)
			csm_pkg::CSM_IDLE: begin
				if (irq_entry || call_plain || call_seg) begin
					sp = sp_step(s.system_stack_internal_sel, inl, 1'b1, 1'b1);
					n.system_stack_internal_sel = sp;
					n.stk_addr = sp_addr(sp, inl);
					n.stk_data = prog_counter;
					n.stk_we = 1'b1;
					n.stk_word = 1'b1;
					n.stk_int = inl;
					n.cap_flags = flag_reg;
					n.seg_pend = irq_entry ? s.seg_push : call_seg;
					if (irq_entry) begin
						n.fsm = csm_pkg::CSM_PUSH_FLG;
					end else if (call_seg) begin
						n.fsm = csm_pkg::CSM_PUSH_SEG;
					end
				end else if (stk_req) begin
					inl = stk_user ? s.mode[`CSM_MODE_USP] : s.mode[`CSM_MODE_SSP];
					sp = stk_user ? s.user_stack_internal_sel : s.system_stack_internal_sel;
					n.stk_word = stk_word;
					n.stk_int = inl;
					n.stk_data = stk_wdata;
					if (stk_push) begin
						sp = sp_step(sp, inl, 1'b1, stk_word);
						n.stk_addr = sp_addr(sp, inl);
						n.stk_we = 1'b1;
					end else begin
						// Pop reads only; old contents stay in place
						n.stk_addr = sp_addr(sp, inl);
						n.stk_rd = 1'b1;
						sp = sp_step(sp, inl, 1'b0, stk_word);
					end
					if (stk_user) begin
						n.user_stack_internal_sel = sp;
					end else begin
						n.system_stack_internal_sel = sp;
					end
				end
			end
			csm_pkg::CSM_PUSH_FLG: begin
				sp = sp_step(s.system_stack_internal_sel, inl, 1'b1, 1'b0);
				n.system_stack_internal_sel = sp;
				n.stk_addr = sp_addr(sp, inl);
				n.stk_data = {8'h00, s.cap_flags};
				n.stk_we = 1'b1;
				n.stk_word = 1'b0;
				n.stk_int = inl;
				n.fsm = s.seg_pend ? csm_pkg::CSM_PUSH_SEG : csm_pkg::CSM_IDLE;
			end
			csm_pkg::CSM_PUSH_SEG: begin
				sp = sp_step(s.system_stack_internal_sel, inl, 1'b1, 1'b0);
				n.system_stack_internal_sel = sp;
				n.stk_addr = sp_addr(sp, inl);
				n.stk_data = {10'h000, s.code_segment_reg};
				n.stk_we = 1'b1;
				n.stk_word = 1'b0;
				n.stk_int = inl;
				n.fsm = csm_pkg::CSM_IDLE;
			end
			default: begin
				n.fsm = csm_pkg::CSM_IDLE;
			end
		endcase
		n.stk_busy = (n.fsm != csm_pkg::CSM_IDLE);

		// Virtual to 22-bit physical address
		if (mmu_req) begin
			n.paddr_vld = 1'b1;
			case (mmu_kind)
				csm_pkg::CSM_ACC_CODE: seg = s.code_segment_reg;
				csm_pkg::CSM_ACC_IRQ:  seg = irq_use_isr ? s.interrupt_segment_reg : s.code_segment_reg;
				csm_pkg::CSM_ACC_DMA:  seg = dma_use_dma_segment_reg ? s.dma_segment_reg : s.interrupt_segment_reg;
				default:               seg = 6'h00;
			endcase
			if (mmu_kind == csm_pkg::CSM_ACC_DATA) begin
				n.paddr = {s.data_page_regs[mmu_vaddr[15:14]], mmu_vaddr[13:0]};
			end else begin
				n.paddr = {seg, mmu_vaddr};
			end
			// Whole segment decides internal or external
			n.paddr_ext = ~INT_SEG_MAP[n.paddr[21:16]];
		end
	end

	// ==========================================================================
	// State register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.fsm <= csm_pkg::CSM_IDLE;
			s.page <= `CSM_PAGE_RESET;
			s.mode <= `CSM_MODE_RESET;
			s.user_stack_internal_sel <= `CSM_SP_RESET;
			s.system_stack_internal_sel <= `CSM_SP_RESET;
			s.code_segment_reg <= `CSM_SEG_RESET;
		end else begin
			s <= n;
		end
	end

	// ==========================================================================
	// Outputs
	assign reg_rdata = s.rd_data;
	assign stk_busy = s.stk_busy;
	assign stk_addr = s.stk_addr;
	assign stk_data = s.stk_data;
	assign stk_we = s.stk_we;
	assign stk_rd = s.stk_rd;
	assign stk_word_out = s.stk_word;
	assign stk_internal = s.stk_int;
	assign internal_clock = s.int_clk_en;
	assign processor_clock = s.cpu_clk_en;
	assign bus_request_grant = s.bus_grant;
	assign ext_lines_float = s.pins_float;
	assign strobes_float = s.strobes_float;
	assign mmu_paddr = s.paddr;
	assign mmu_external = s.paddr_ext;
	assign mmu_valid = s.paddr_vld;

endmodule // csm_core_regs

`default_nettype wire

// >>> hw/csm_defines.svh
// Constants for the core mode, page and stack pointer register bank
// ==========================================================================
// Operation
// - Page pointer holds 6-bit page, retained
// - Page pointer bits 1:0 always read zero
// - Mode register resets to E0h
// - Mode bit 7 puts system stack internal
// - Mode bit 6 puts user stack internal
// - Mode bit 5 halves the oscillator clock
// - Mode bits 4:2 prescale internal clock 1-8
// - Mode bit 1 enables bus request input
// - Mode bit 0 floats external bus lines
// - Float leaves general purpose port pins alone
// - Push pre-decrements, pop post-increments pointer
// - Pop never writes stack contents
// - Interrupt pushes PC, flags, optionally segment
// - Call pushes PC; segment call adds segment
// - Internal stack uses low pointer byte only
// - Four megabytes: 64 segments, 4 pages each
// - Each segment wholly internal or external
// - Four data page, three segment registers
// - Segment register chosen by access kind
// - Data access: page register prefixes 14 bits
// - Code and DMA: segment prefixes 16 bits
`ifndef CSM_DEFINES_SVH
`define CSM_DEFINES_SVH

// ==========================================================================
// Register file addresses
`define CSM_R_DPR_RELOC  8'he0
`define CSM_R_PAGE       8'hea
`define CSM_R_MODE       8'heb
`define CSM_R_USP_HI     8'hec
`define CSM_R_USP_LO     8'hed
`define CSM_R_SSP_HI     8'hee
`define CSM_R_SSP_LO     8'hef
`define CSM_R_DPR0       8'hf0
`define CSM_R_CSR        8'hf4
`define CSM_R_EXTENDED_MODE_REG_TWO       8'hf6
`define CSM_R_ISR        8'hf8
`define CSM_R_DMA_SEGMENT_REG      8'hf9
`define CSM_MMU_PAGE     6'h15

// ==========================================================================
// Field positions and reset values
`define CSM_MODE_SSP     7
`define CSM_MODE_USP     6
`define CSM_MODE_OSCILLATOR_HALVING    5
`define CSM_MODE_PRS_HI  4
`define CSM_MODE_PRS_LO  2
`define CSM_MODE_BUS_REQUEST_ENABLE   1
`define CSM_MODE_BUS_FLOAT_ENABLE    0
`define CSM_EXTENDED_MODE_REG_TWO_SEGPUSH 7
`define CSM_EXTENDED_MODE_REG_TWO_RELOC   5
`define CSM_MODE_RESET   8'he0
`define CSM_PAGE_RESET   6'h00
`define CSM_SP_RESET     16'h0000
`define CSM_SEG_RESET    6'h00

`endif

// >>> hw/csm_pkg.sv
// Types for the core mode, page and stack pointer register bank
`default_nettype none
package csm_pkg;

	typedef enum logic [3:0] {
		CSM_IDLE     = 4'b0001,
		CSM_PUSH_FLG = 4'b0010,
		CSM_PUSH_SEG = 4'b0100,
		CSM_SPARE    = 4'b1000
	} csm_fsm_t;

	typedef enum logic [1:0] {
		CSM_ACC_CODE = 2'h0,
		CSM_ACC_IRQ  = 2'h1,
		CSM_ACC_DATA = 2'h2,
		CSM_ACC_DMA  = 2'h3
	} csm_access_t;

	typedef struct packed {
		logic [5:0]      page;
		logic [7:0]      mode;
		logic [15:0]     user_stack_internal_sel;
		logic [15:0]     system_stack_internal_sel;
		logic [3:0][7:0] data_page_regs;
		logic [5:0]      code_segment_reg;
		logic [5:0]      interrupt_segment_reg;
		logic [5:0]      dma_segment_reg;
		logic            seg_push;
		logic            dpr_reloc;
		logic [7:0]      rd_data;
		csm_fsm_t        fsm;
		logic            seg_pend;
		logic [7:0]      cap_flags;
		logic [15:0]     stk_addr;
		logic [15:0]     stk_data;
		logic            stk_we;
		logic            stk_rd;
		logic            stk_word;
		logic            stk_int;
		logic            stk_busy;
		logic            osc_tog;
		logic [2:0]      pre_cnt;
		logic            int_clk_en;
		logic            cpu_clk_en;
		logic            bus_grant;
		logic            strobes_float;
		logic [15:0]     pins_float;
		logic [21:0]     paddr;
		logic            paddr_ext;
		logic            paddr_vld;
	} csm_state_t;

endpackage

`default_nettype wire

// >>> tb/csm_core_regs_assertions.sv
// Port checker for the core mode and stack register bank
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Checker
module csm_core_regs_chk (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        stk_req,
	input wire logic        stk_push,
	input wire logic        stk_busy,
	input wire logic        stk_we,
	input wire logic        stk_rd,
	input wire logic        irq_entry,
	input wire logic        call_plain,
	input wire logic        call_seg,
	input wire logic        bus_request_pin,
	input wire logic        bus_request_grant,
	input wire logic [15:0] ext_addr_lines,
	input wire logic [15:0] ext_lines_float,
	input wire logic        strobes_float,
	input wire logic        mmu_req,
	input wire logic        mmu_valid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic take;
	assign take = stk_req && !stk_busy && !irq_entry && !call_plain && !call_seg;
	sequence mode_wr;
		reg_wr && reg_addr == 8'heb;
	endsequence
	sequence mode_rd;
		reg_rd && !reg_wr && reg_addr == 8'heb;
	endsequence
	sequence irq_start;
		irq_entry && !stk_busy;
	endsequence
	mode_rw_a: assert property (mode_wr ##2 mode_rd |=> reg_rdata == $past(reg_wdata, 3))
		else $error("mode readback differs");
	page_low_a: assert property (reg_rd && reg_addr == 8'hea |=> reg_rdata[1:0] == 2'h0)
		else $error("page low bits set");
	grant_off_a: assert property (!bus_request_pin |=> !bus_request_grant)
		else $error("grant without request");
	float_mask_a: assert property ((ext_lines_float & ~$past(ext_addr_lines)) == 16'h0000)
		else $error("general pin floated");
	float_strobe_a: assert property (ext_lines_float != 16'h0000 |-> strobes_float)
		else $error("strobes not floated");
	push_write_a: assert property (take && stk_push |=> stk_we && !stk_rd)
		else $error("push not written");
	pop_read_a: assert property (take && !stk_push |=> stk_rd && !stk_we)
		else $error("pop wrote stack");
	irq_push_a: assert property (irq_start |=> stk_we [*2])
		else $error("irq pushes missing");
	call_push_a: assert property (call_plain && !stk_busy && !irq_entry |=> stk_we ##1 !stk_we)
		else $error("call push count wrong");
	mmu_answer_a: assert property (mmu_req |=> mmu_valid)
		else $error("translation not answered");
endmodule // csm_core_regs_chk

bind csm_core_regs csm_core_regs_chk i_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .stk_req(stk_req), .stk_push(stk_push),
	.stk_busy(stk_busy), .stk_we(stk_we), .stk_rd(stk_rd), .irq_entry(irq_entry), .call_plain(call_plain),
	.call_seg(call_seg), .bus_request_pin(bus_request_pin), .bus_request_grant(bus_request_grant),
	.ext_addr_lines(ext_addr_lines), .ext_lines_float(ext_lines_float), .strobes_float(strobes_float),
	.mmu_req(mmu_req), .mmu_valid(mmu_valid)
);

`default_nettype wire

// >>> tb/csm_stack_model.sv
// Stack memory seen by the core side of the register bank
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Stack write log
module csm_stack_model (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        stk_we,
	input  wire logic        stk_internal,
	input  wire logic [15:0] stk_addr,
	output logic      [7:0]  pushes,
	output logic             misplaced
);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pushes    <= 8'h00;
			misplaced <= 1'b0;
		end else if (stk_we) begin
			pushes <= pushes + 8'h01;
			// Groups E and F hold system and paged registers
			if (stk_internal && stk_addr[7:0] >= 8'he0) begin
				misplaced <= 1'b1;
			end
		end
	end
endmodule // csm_stack_model

`default_nettype wire

// >>> tb/tb_core_system_mode_stack_regs.sv
// Self-checking bench for the core mode and stack register bank
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Bench
module tb_core_system_mode_stack_regs;
	logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, spp_load = 1'b0, stk_req = 1'b0;
	logic stk_push = 1'b0, stk_user = 1'b0, stk_word = 1'b0, irq_entry = 1'b0, call_plain = 1'b0;
	logic call_seg = 1'b0, bus_request_pin = 1'b0, mmu_req = 1'b0, irq_use_isr = 1'b0, dma_use_dma_segment_reg = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, flag_reg = 8'h5a;
	logic [5:0] spp_value = 6'h00;
	logic [15:0] stk_wdata = 16'h0000, prog_counter = 16'h1234, ext_addr_lines = 16'h0000, mmu_vaddr = 16'h0000;
	csm_pkg::csm_access_t mmu_kind = csm_pkg::CSM_ACC_CODE;
	logic stk_busy, stk_we, stk_rd, stk_word_out, stk_internal, internal_clock, processor_clock;
	logic bus_request_grant, strobes_float, mmu_external, mmu_valid, misplaced;
	logic [7:0] reg_rdata, pushes;
	logic [15:0] stk_addr, stk_data, ext_lines_float;
	logic [21:0] mmu_paddr;
	int errors = 0;
	int checks = 0;

	csm_core_regs i_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .spp_load(spp_load), .spp_value(spp_value),
		.stk_req(stk_req), .stk_push(stk_push), .stk_user(stk_user), .stk_word(stk_word), .stk_wdata(stk_wdata),
		.irq_entry(irq_entry), .call_plain(call_plain), .call_seg(call_seg), .prog_counter(prog_counter),
		.flag_reg(flag_reg), .stk_busy(stk_busy), .stk_addr(stk_addr), .stk_data(stk_data), .stk_we(stk_we),
		.stk_rd(stk_rd), .stk_word_out(stk_word_out), .stk_internal(stk_internal),
		.internal_clock(internal_clock), .processor_clock(processor_clock), .bus_request_pin(bus_request_pin),
		.bus_request_grant(bus_request_grant), .ext_addr_lines(ext_addr_lines),
		.ext_lines_float(ext_lines_float), .strobes_float(strobes_float), .mmu_req(mmu_req),
		.mmu_kind(mmu_kind), .irq_use_isr(irq_use_isr), .dma_use_dma_segment_reg(dma_use_dma_segment_reg), .mmu_vaddr(mmu_vaddr),
		.mmu_paddr(mmu_paddr), .mmu_external(mmu_external), .mmu_valid(mmu_valid)
	);
	csm_stack_model i_mem (
		.clk_sys(clk_sys), .rst_n(rst_n), .stk_we(stk_we), .stk_internal(stk_internal),
		.stk_addr(stk_addr), .pushes(pushes), .misplaced(misplaced)
	);

	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Wide enough for the longest bundled compare
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic test_done;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask

	// Read data lands one edge after the strobe
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		chk(reg_rdata, e);
	endtask

	task automatic sop(input logic p, input logic u, input logic [15:0] d);
		@(negedge clk_sys);
		stk_req = 1'b1;
		stk_push = p;
		stk_user = u;
		stk_wdata = d;
		@(negedge clk_sys);
		stk_req = 1'b0;
	endtask

	task automatic apush(input int k, input int e);
		int n0;
		n0 = pushes;
		@(negedge clk_sys);
		irq_entry = (k == 0);
		call_plain = (k == 1);
		call_seg = (k == 2);
		@(negedge clk_sys);
		{irq_entry, call_plain, call_seg} = 3'b000;
		repeat (4) @(negedge clk_sys);
		chk(pushes - n0, e);
	endtask

	task automatic mop(input csm_pkg::csm_access_t k, input logic [15:0] v, input logic [21:0] e);
		@(negedge clk_sys);
		mmu_kind = k;
		mmu_vaddr = v;
		mmu_req = 1'b1;
		@(negedge clk_sys);
		mmu_req = 1'b0;
		chk({mmu_valid, mmu_paddr}, {1'b1, e});
	endtask

	task automatic t_page;
		@(negedge clk_sys);
		spp_value = 6'h3f;
		spp_load = 1'b1;
		@(negedge clk_sys);
		spp_load = 1'b0;
		rc(8'hea, 8'hfc);
		wr(8'hea, 8'h57);
		repeat (5) @(negedge clk_sys);
		rc(8'hea, 8'h54);
		rc(8'h05, 8'h00);
		$display("t_page done");
	endtask

	task automatic t_stack;
		wr(8'heb, 8'h80);
		wr(8'hee, 8'h01);
		wr(8'hef, 8'hd0);
		wr(8'hec, 8'h12);
		wr(8'hed, 8'hd0);
		sop(1'b1, 1'b0, 16'h00a5);
		chk({stk_internal, stk_addr}, {1'b1, 16'h00cf});
		sop(1'b1, 1'b1, 16'h00a5);
		chk({stk_internal, stk_addr}, {1'b0, 16'h12cf});
		wr(8'heb, 8'h00);
		stk_word = 1'b1;
		sop(1'b1, 1'b0, 16'hbeef);
		chk({stk_we, stk_internal, stk_addr, stk_data}, {2'b10, 16'h01cd, 16'hbeef});
		rc(8'hef, 8'hcd);
		sop(1'b0, 1'b0, 16'h0000);
		chk({stk_rd, stk_we, stk_addr}, {2'b10, 16'h01cd});
		rc(8'hef, 8'hcf);
		wr(8'heb, 8'h40);
		sop(1'b1, 1'b1, 16'h1111);
		chk({stk_internal, stk_addr}, {1'b1, 16'h00cd});
		rc(8'hec, 8'h12);
		$display("t_stack done");
	endtask

	task automatic t_auto;
		apush(0, 2);
		chk({stk_word_out, stk_data}, {1'b0, 16'h005a});
		wr(8'hf6, 8'h80);
		apush(0, 3);
		apush(1, 1);
		chk({stk_word_out, stk_data}, {1'b1, 16'h1234});
		apush(2, 2);
		$display("t_auto done");
	endtask

	task automatic t_mmu;
		wr(8'hf2, 8'h9a);
		wr(8'hf4, 8'h05);
		rc(8'hf4, 8'h05);
		mop(csm_pkg::CSM_ACC_DATA, 16'h8123, {8'h9a, 14'h0123});
		mop(csm_pkg::CSM_ACC_CODE, 16'h1234, {6'h05, 16'h1234});
		chk(mmu_external, 1'b1);
		wr(8'hf8, 8'h0a);
		wr(8'hf9, 8'h0c);
		mop(csm_pkg::CSM_ACC_IRQ, 16'h0042, {6'h05, 16'h0042});
		mop(csm_pkg::CSM_ACC_DMA, 16'h0042, {6'h0a, 16'h0042});
		irq_use_isr = 1'b1;
		dma_use_dma_segment_reg = 1'b1;
		mop(csm_pkg::CSM_ACC_IRQ, 16'h0042, {6'h0a, 16'h0042});
		mop(csm_pkg::CSM_ACC_DMA, 16'h0042, {6'h0c, 16'h0042});
		// Relocated data page registers leave their page slots empty
		wr(8'hf6, 8'ha0);
		rc(8'hf6, 8'ha0);
		wr(8'he1, 8'h33);
		rc(8'he1, 8'h33);
		rc(8'hf1, 8'h00);
		mop(csm_pkg::CSM_ACC_DATA, 16'h4000, {8'h33, 14'h0000});
		$display("t_mmu done");
	endtask

	task automatic t_bus;
		wr(8'heb, 8'h03);
		rc(8'heb, 8'h03);
		bus_request_pin = 1'b1;
		ext_addr_lines = 16'h001f;
		repeat (3) @(negedge clk_sys);
		chk({bus_request_grant, strobes_float, ext_lines_float}, {2'b11, 16'h001f});
		wr(8'heb, 8'h00);
		repeat (3) @(negedge clk_sys);
		chk({bus_request_grant, strobes_float, ext_lines_float}, 18'h0);
		$display("t_bus done");
	endtask

	task automatic t_clk;
		int ci;
		int cp;
		rc(8'heb, 8'he0);
		for (int p = 0; p < 9; p++) begin
			if (p > 0) begin
				wr(8'heb, {3'b110, 3'(p - 1), 2'b00});
			end
			repeat (10) @(negedge clk_sys);
			ci = 0;
			cp = 0;
			// Whole prescale periods so the phase does not matter
			repeat (8 * (p > 0 ? p : 1)) begin
				@(negedge clk_sys);
				ci += internal_clock;
				cp += processor_clock;
			end
			chk(ci, (p == 0) ? 4 : 8 * p);
			chk(cp, (p == 0) ? 4 : 8);
		end
		$display("t_clk done");
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		t_clk();
		t_page();
		t_stack();
		t_auto();
		t_mmu();
		t_bus();
		chk(misplaced, 1'b0);
		test_done();
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		test_done();
	end
endmodule // tb_core_system_mode_stack_regs

`default_nettype wire
